// file: pkg/home_backup_pkg.sv
// Constants and types shared by the home store and backup gate
package home_backup_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int HOLD_MS = 1000;
    localparam int WINDOW_MS = 3000;
    localparam int DEBOUNCE_US = 10;
    localparam int LED_HALF_MS = 250;
    localparam int SHOW_BOTH_MS = 500;
    localparam int HOLD_CYCLES = HOLD_MS * (CLK_HZ / 1000);
    localparam int WINDOW_CYCLES = WINDOW_MS * (CLK_HZ / 1000);
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int LED_HALF_CYCLES = LED_HALF_MS * (CLK_HZ / 1000);
    localparam int SHOW_BOTH_CYCLES = SHOW_BOTH_MS * (CLK_HZ / 1000);
    localparam logic [15:0] ACCESS_KEY_ID = 16'h0020;
    localparam logic [15:0] WRITE_KEY_ID = 16'h0021;
    localparam logic [15:0] RESTORE_CMD_ID = 16'h00cb;
    localparam logic [15:0] SAVE_CMD_ID = 16'h00cc;
    localparam logic [31:0] ACCESS_KEY_CODE = 32'h01391955;
    localparam logic [31:0] WRITE_KEY_CODE = 32'h75db9c97;
    localparam logic [31:0] KEY_RESET = 32'h00000000;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_HOLD = 6'h02,
        ST_BLINK = 6'h04,
        ST_WAIT_PRESS = 6'h08,
        ST_STORE = 6'h10,
        ST_SHOW = 6'h20
    } home_state_t;
endpackage : home_backup_pkg

// file: logic/button_debounce.sv
// Debouncer for the home set button after synchronisation
module button_debounce #(
    parameter int CYCLES = 2500
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Synchronised raw level and clean level
    input wire logic raw,
    output logic clean
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic clean_nxt;

    initial
    begin
        if (CYCLES < 1)
            $error("debounce count must be at least one");
    end

    always_comb
    begin
        cnt_nxt = 32'h0;
        clean_nxt = clean;
        if (raw != clean)
        begin
            // Level must hold unchanged for the full count
            if (cnt_r >= 32'(CYCLES - 1))
                clean_nxt = raw;
            else
                cnt_nxt = cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 32'h0;
            clean <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            clean <= clean_nxt;
        end
    end
endmodule : button_debounce

// file: logic/home_store_and_backup_gate.sv
// Home set sequencer and key-gated backup command gate
// What this block and its fieldbus master do
// RQ1: Holding the home button one second with power on starts the LED blinking red and green.
// RQ2: The operator must release the button within three seconds of blinking start.
// RQ3: A re-press within three seconds of release stores home, shows red and green, then green.
// RQ4: Either window passing three seconds abandons the sequence and returns to steady green.
// RQ5: The home position is written to non-volatile storage; none is defined when shipped.
// RQ6: Home setting should be done only once since storage wears out after about 100,000 writes.
// RQ7: Backup reads and writes need the access key parameter 0020h at 01391955h; it resets to zero.
// RQ8: Backup writes need the write key parameter 0021h at 75DB9C97h; it resets to zero.
// RQ9: Command 00CCh copies all current data into the backup area.
// RQ10: The master loads both keys before issuing the save command.
// RQ11: Command 00CBh restores all data from the backup area.
// RQ12: The master loads the access key before issuing the restore command.
// RQ13: A backup command without its keys leaves backup and working data untouched.
// RQ14: The button is debounced before any of its intervals are timed.
module home_store_and_backup_gate
    import home_backup_pkg::*;
#(
    parameter int HOLD_CNT = HOLD_CYCLES,
    parameter int WINDOW_CNT = WINDOW_CYCLES,
    parameter int BLINK_CNT = LED_HALF_CYCLES,
    parameter int SHOW_CNT = SHOW_BOTH_CYCLES,
    parameter int DEBOUNCE_CNT = DEBOUNCE_CYCLES,
    parameter int POS_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Operator side
    input wire logic home_button_n,
    input wire logic power_on,
    output logic power_alarm_led_red,
    output logic power_alarm_led_green,
    // Present position and non-volatile home store
    input wire logic [POS_W-1:0] present_pos,
    output logic home_store,
    output logic [POS_W-1:0] home_pos,
    output logic home_valid,
    input wire logic home_loaded_valid,
    // Fieldbus parameter writes and reads
    input wire logic param_wr,
    input wire logic [15:0] param_id,
    input wire logic [31:0] param_data,
    input wire logic param_rd,
    output logic [31:0] param_rdata,
    // Backup engine commands
    output logic backup_save,
    output logic backup_restore,
    output logic backup_refused
);
    import home_backup_pkg::*;

    initial
    begin
        if (HOLD_CNT < 1 || WINDOW_CNT < 1 || BLINK_CNT < 1 || SHOW_CNT < 1)
            $error("timing counts must be at least one");
    end

    // Reset release and pin synchronisers
    logic [1:0] rst_sync_r;
    logic rst_s_n;
    logic [1:0] btn_sync_r;
    logic [1:0] pwr_sync_r;
    logic btn_clean;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_s_n = rst_sync_r[1];

    always_ff @(posedge clk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            btn_sync_r <= 2'h0;
            pwr_sync_r <= 2'h0;
        end
        else
        begin
            btn_sync_r <= {btn_sync_r[0], ~home_button_n};
            pwr_sync_r <= {pwr_sync_r[0], power_on};
        end
    end

    button_debounce #(.CYCLES(DEBOUNCE_CNT)) u_debounce ( // RQ14
        .clk(clk),
        .rst_n(rst_s_n),
        .raw(btn_sync_r[1]),
        .clean(btn_clean)
    );

    // Home sequencer
    home_state_t state_r, state_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic [31:0] blk_r, blk_nxt;
    logic blink_ph_r, blink_ph_nxt;
    logic red_nxt, green_nxt, store_nxt, hvalid_nxt;
    logic [POS_W-1:0] hpos_nxt;
    logic pressed;

    assign pressed = btn_clean && pwr_sync_r[1];

    always_comb
    begin
        state_nxt = state_r;
        tmr_nxt = tmr_r + 32'h1;
        blk_nxt = 32'h0;
        blink_ph_nxt = 1'b0;
        store_nxt = 1'b0;
        hpos_nxt = home_pos;
        hvalid_nxt = home_valid | home_loaded_valid;
        red_nxt = 1'b0;
        green_nxt = pwr_sync_r[1];
        case (state_r)
            ST_IDLE:
            begin
                tmr_nxt = 32'h0;
                if (pressed)
                    state_nxt = ST_HOLD;
            end
            ST_HOLD:
            begin
                if (!pressed)
                    state_nxt = ST_IDLE;
                else if (tmr_r >= 32'(HOLD_CNT - 1)) // RQ1
                begin
                    state_nxt = ST_BLINK;
                    tmr_nxt = 32'h0;
                end
            end
            ST_BLINK, ST_WAIT_PRESS:
            begin
                // Both colours blink together while the sequence runs
                blk_nxt = blk_r + 32'h1;
                blink_ph_nxt = blink_ph_r;
                if (blk_r >= 32'(BLINK_CNT - 1))
                begin
                    blk_nxt = 32'h0;
                    blink_ph_nxt = ~blink_ph_r;
                end
                red_nxt = ~blink_ph_nxt; // RQ1
                green_nxt = ~blink_ph_nxt;
                if (tmr_r >= 32'(WINDOW_CNT - 1)) // RQ4
                begin
                    state_nxt = ST_IDLE;
                    red_nxt = 1'b0;
                    green_nxt = 1'b1;
                end
                else if (state_r == ST_BLINK && !btn_clean) // RQ2
                begin
                    state_nxt = ST_WAIT_PRESS;
                    tmr_nxt = 32'h0;
                end
                else if (state_r == ST_WAIT_PRESS && pressed) // RQ3
                    state_nxt = ST_STORE;
            end
            ST_STORE:
            begin
                // One write per completed sequence limits wear
                store_nxt = 1'b1; // RQ5
                hpos_nxt = present_pos; // RQ3
                hvalid_nxt = 1'b1;
                red_nxt = 1'b1;
                state_nxt = ST_SHOW;
                tmr_nxt = 32'h0;
            end
            ST_SHOW:
            begin
                red_nxt = 1'b1; // RQ3
                if (tmr_r >= 32'(SHOW_CNT - 1))
                begin
                    red_nxt = 1'b0;
                    if (!btn_clean)
                        state_nxt = ST_IDLE;
                end
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            state_r <= ST_IDLE;
            tmr_r <= 32'h0;
            blk_r <= 32'h0;
            blink_ph_r <= 1'b0;
            home_store <= 1'b0;
            home_pos <= '0;
            home_valid <= 1'b0; // RQ5
            power_alarm_led_red <= 1'b0;
            power_alarm_led_green <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            blk_r <= blk_nxt;
            blink_ph_r <= blink_ph_nxt;
            home_store <= store_nxt;
            home_pos <= hpos_nxt;
            home_valid <= hvalid_nxt;
            power_alarm_led_red <= red_nxt;
            power_alarm_led_green <= green_nxt;
        end
    end

    // Key registers and maintenance command gate
    logic [31:0] akey_r, akey_nxt, wkey_r, wkey_nxt, rdata_nxt;
    logic save_nxt, restore_nxt, refused_nxt;
    logic access_ok, write_ok;

    assign access_ok = (akey_r == ACCESS_KEY_CODE); // RQ7
    assign write_ok = access_ok && (wkey_r == WRITE_KEY_CODE); // RQ8

    always_comb
    begin
        akey_nxt = akey_r;
        wkey_nxt = wkey_r;
        save_nxt = 1'b0;
        restore_nxt = 1'b0;
        refused_nxt = 1'b0;
        rdata_nxt = param_rdata;
        if (param_wr)
        begin
            if (param_id == ACCESS_KEY_ID)
                akey_nxt = param_data;
            else if (param_id == WRITE_KEY_ID)
                wkey_nxt = param_data;
            else if (param_id == SAVE_CMD_ID)
            begin
                save_nxt = write_ok; // RQ9
                refused_nxt = !write_ok; // RQ13
            end
            else if (param_id == RESTORE_CMD_ID)
            begin
                restore_nxt = access_ok; // RQ11
                refused_nxt = !access_ok; // RQ13
            end
        end
        if (param_rd)
        begin
            if (param_id == ACCESS_KEY_ID)
                rdata_nxt = akey_r;
            else if (param_id == WRITE_KEY_ID)
                rdata_nxt = wkey_r;
            else
                rdata_nxt = 32'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_s_n)
    begin
        if (!rst_s_n)
        begin
            akey_r <= KEY_RESET; // RQ7
            wkey_r <= KEY_RESET; // RQ8
            backup_save <= 1'b0;
            backup_restore <= 1'b0;
            backup_refused <= 1'b0;
            param_rdata <= 32'h0;
        end
        else
        begin
            akey_r <= akey_nxt;
            wkey_r <= wkey_nxt;
            backup_save <= save_nxt;
            backup_restore <= restore_nxt;
            backup_refused <= refused_nxt;
            param_rdata <= rdata_nxt;
        end
    end

    AST_SAVE_NEEDS_KEYS: assert property (@(posedge clk) disable iff (!rst_s_n) // RQ8
        backup_save |-> $past(write_ok) && $past(param_id) == SAVE_CMD_ID)
        else $error("save issued without both keys");
    AST_RESTORE_NEEDS_KEY: assert property (@(posedge clk) disable iff (!rst_s_n) // RQ7
        backup_restore |-> $past(access_ok) && $past(param_id) == RESTORE_CMD_ID)
        else $error("restore issued without access key");
    AST_SAVE_CMD: assert property (@(posedge clk) disable iff (!rst_s_n) // RQ9
        param_wr && param_id == SAVE_CMD_ID && write_ok |=> backup_save)
        else $error("save command not executed");
    AST_RESTORE_CMD: assert property (@(posedge clk) disable iff (!rst_s_n) // RQ11
        param_wr && param_id == RESTORE_CMD_ID && access_ok |=> backup_restore)
        else $error("restore command not executed");
    AST_REFUSE: assert property (@(posedge clk) disable iff (!rst_s_n) // RQ13
        param_wr && param_id == SAVE_CMD_ID && !write_ok |=> !backup_save && backup_refused)
        else $error("keyless save not refused");
    AST_STORE_POS: assert property (@(posedge clk) disable iff (!rst_s_n) // RQ3
        state_r == ST_STORE |=> home_store && home_pos == $past(present_pos)
        && power_alarm_led_red && home_valid)
        else $error("home not stored on re-press");
    AST_HOLD_TO_BLINK: assert property (@(posedge clk) disable iff (!rst_s_n) // RQ1
        state_r == ST_BLINK && $past(state_r) == ST_HOLD
        |-> $past(tmr_r) == 32'(HOLD_CNT - 1) && $past(pressed))
        else $error("blink started at wrong hold time");
    AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_s_n) // RQ4
        (state_r == ST_BLINK || state_r == ST_WAIT_PRESS) && tmr_r >= 32'(WINDOW_CNT - 1)
        |=> state_r == ST_IDLE && !home_store && !power_alarm_led_red)
        else $error("window timeout not abandoned");
    AST_STORE_ONLY_AFTER_SEQ: assert property (@(posedge clk) disable iff (!rst_s_n) // RQ5
        home_store |-> $past(state_r) == ST_STORE)
        else $error("home write outside sequence");
endmodule : home_store_and_backup_gate

// file: test/operator_master_model.sv
// Operator button and fieldbus master model for the home and backup gate
module operator_master_model (
    // Clock
    input wire logic clk,
    // Operator button, low while pressed
    output logic home_button_n,
    // Parameter bus
    output logic param_wr,
    output logic param_rd,
    output logic [15:0] param_id,
    output logic [31:0] param_data,
    input wire logic [31:0] param_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        home_button_n = 1'b1;
        param_wr = 1'b0;
        param_rd = 1'b0;
        param_id = 16'hffff;
        param_data = 32'h0;
    end

    task automatic button(input logic pressed);
    begin
        @(posedge clk);
        home_button_n <= ~pressed;
    end
    endtask : button

    // Released bus shows inverted values, so stale id or data never match
    task automatic access(input logic rd, input logic [15:0] id, input logic [31:0] data);
    begin
        @(posedge clk);
        param_wr <= ~rd;
        param_rd <= rd;
        param_id <= id;
        param_data <= data;
        @(posedge clk);
        param_wr <= 1'b0;
        param_rd <= 1'b0;
        param_id <= ~id;
        param_data <= ~data;
    end
    endtask : access

    // Keys always go ahead of the command
    task automatic save_cmd;
    begin
        access(1'b0, 16'h0020, 32'h01391955);
        access(1'b0, 16'h0021, 32'h75db9c97);
        access(1'b0, 16'h00cc, 32'h0);
    end
    endtask : save_cmd

    task automatic restore_cmd;
    begin
        access(1'b0, 16'h0020, 32'h01391955);
        access(1'b0, 16'h00cb, 32'h0);
    end
    endtask : restore_cmd
endmodule : operator_master_model

// file: test/tb.sv
// Self-checking bench for the home store and backup gate
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic home_button_n, param_wr, param_rd;
    logic [15:0] param_id;
    logic [31:0] param_data, param_rdata, home_pos;
    logic [31:0] present_pos = 32'h00005a3c;
    logic power_on = 1'b1;
    logic home_loaded_valid = 1'b0;
    logic red, green, home_store, home_valid, save, restore, refused;
    logic seen;
    int num_errors = 0;
    int compares = 0;
    int stores = 0;

    always #2 clk = ~clk;
    always @(posedge clk) if (home_store === 1'b1) stores <= stores + 1;

    // Short counts keep the run small
    home_store_and_backup_gate #(.HOLD_CNT(20), .WINDOW_CNT(60), .BLINK_CNT(4),
        .SHOW_CNT(8), .DEBOUNCE_CNT(2)) home_store_and_backup_gate_i (
        .clk(clk), .rst_n(rst_n), .home_button_n(home_button_n), .power_on(power_on),
        .power_alarm_led_red(red), .power_alarm_led_green(green),
        .present_pos(present_pos), .home_store(home_store), .home_pos(home_pos),
        .home_valid(home_valid), .home_loaded_valid(home_loaded_valid), .param_wr(param_wr),
        .param_id(param_id), .param_data(param_data), .param_rd(param_rd),
        .param_rdata(param_rdata), .backup_save(save), .backup_restore(restore),
        .backup_refused(refused));

    operator_master_model op_i (.clk(clk), .home_button_n(home_button_n),
        .param_wr(param_wr), .param_rd(param_rd), .param_id(param_id),
        .param_data(param_data), .param_rdata(param_rdata));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    end
    endtask : check

    task automatic flags(input logic [2:0] exp);
    begin
        check("save_restore_refused", {29'h0, exp}, {29'h0, save, restore, refused});
    end
    endtask : flags

    task automatic leds(input logic [1:0] exp);
    begin
        check("led_red_green", {30'h0, exp}, {30'h0, red, green});
    end
    endtask : leds

    task automatic wait_red(input int limit);
    begin
        seen = 1'b0;
        for (int i = 0; i < limit && !seen; i++)
        begin
            @(posedge clk);
            #1 seen = (red === 1'b1);
        end
    end
    endtask : wait_red

    task automatic reset_values;
    begin
        op_i.access(1'b1, 16'h0020, 32'h0);
        #1 check("access_key", 32'h0, param_rdata);
        op_i.access(1'b1, 16'h0021, 32'h0);
        #1 check("write_key", 32'h0, param_rdata);
        check("home_valid", 32'h0, {31'h0, home_valid});
        leds(2'b01);
    end
    endtask : reset_values

    task automatic backup_gate;
    begin
        op_i.access(1'b0, 16'h00cb, 32'h0);
        #1 flags(3'b001);
        op_i.access(1'b0, 16'h0020, 32'h01391954);
        op_i.access(1'b0, 16'h00cb, 32'h0);
        #1 flags(3'b001);
        op_i.access(1'b0, 16'h0020, 32'h01391955);
        op_i.access(1'b0, 16'h00cc, 32'h0);
        #1 flags(3'b001);
        op_i.access(1'b1, 16'h0020, 32'h0);
        #1 check("access_key", 32'h01391955, param_rdata);
        op_i.restore_cmd();
        #1 flags(3'b010);
        op_i.save_cmd();
        #1 flags(3'b100);
        op_i.access(1'b0, 16'h0030, 32'h12345678);
        op_i.access(1'b1, 16'h0030, 32'h0);
        #1 check("unmapped", 32'h0, param_rdata);
        op_i.access(1'b0, 16'h0021, 32'h0);
        op_i.access(1'b0, 16'h00cc, 32'h0);
        #1 flags(3'b001);
    end
    endtask : backup_gate

    task automatic button_glitch;
    begin
        op_i.button(1'b1);
        op_i.button(1'b0);
        wait_red(40);
        check("glitch_blink", 32'h0, {31'h0, seen});
        // Bouncy hold: short drops must not restart the hold timer
        op_i.button(1'b1);
        repeat (4)
        begin
            repeat (4) @(posedge clk);
            op_i.button(1'b0);
            op_i.button(1'b1);
        end
        wait_red(40);
        check("bounce_blink", 32'h1, {31'h0, seen});
        op_i.button(1'b0);
        repeat (70) @(posedge clk);
    end
    endtask : button_glitch

    task automatic power_gate;
    begin
        @(posedge clk);
        power_on <= 1'b0;
        repeat (4) @(posedge clk);
        #1 leds(2'b00);
        op_i.button(1'b1);
        wait_red(40);
        check("unpowered_blink", 32'h0, {31'h0, seen});
        op_i.button(1'b0);
        repeat (6) @(posedge clk);
        power_on <= 1'b1;
        repeat (4) @(posedge clk);
        #1 leds(2'b01);
    end
    endtask : power_gate

    task automatic reset_again;
    begin
        op_i.access(1'b0, 16'h0021, 32'h75db9c97);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1 check("home_valid_rst", 32'h0, {31'h0, home_valid});
        leds(2'b00);
        repeat (5) @(posedge clk);
        op_i.access(1'b1, 16'h0020, 32'h0);
        #1 check("access_key_rst", 32'h0, param_rdata);
        op_i.access(1'b1, 16'h0021, 32'h0);
        #1 check("write_key_rst", 32'h0, param_rdata);
        op_i.access(1'b0, 16'h00cb, 32'h0);
        #1 flags(3'b001);
        @(posedge clk);
        home_loaded_valid <= 1'b1;
        @(posedge clk);
        home_loaded_valid <= 1'b0;
        #1 check("home_loaded", 32'h1, {31'h0, home_valid});
    end
    endtask : reset_again

    task automatic windows_expire;
    begin
        op_i.button(1'b1);
        wait_red(40);
        check("blink", 32'h1, {31'h0, seen});
        repeat (70) @(posedge clk);
        #1 leds(2'b01);
        op_i.button(1'b0);
        repeat (10) @(posedge clk);
        op_i.button(1'b1);
        wait_red(40);
        op_i.button(1'b0);
        repeat (70) @(posedge clk);
        #1 leds(2'b01);
        check("stores", 32'h0, stores);
    end
    endtask : windows_expire

    task automatic home_set;
    begin
        @(posedge clk);
        present_pos <= 32'h0001c3d2;
        op_i.button(1'b1);
        wait_red(40);
        check("blink", 32'h1, {31'h0, seen});
        op_i.button(1'b0);
        repeat (8) @(posedge clk);
        op_i.button(1'b1);
        for (int i = 0; i < 30 && stores == 0; i++) @(posedge clk);
        #1 check("stores", 32'h1, stores);
        check("home_pos", 32'h0001c3d2, home_pos);
        check("home_valid", 32'h1, {31'h0, home_valid});
        leds(2'b11);
        op_i.button(1'b0);
        present_pos <= 32'h00007e11;
        repeat (30) @(posedge clk);
        #1 leds(2'b01);
        check("home_pos_held", 32'h0001c3d2, home_pos);
    end
    endtask : home_set

    task automatic test_done;
    begin
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask : test_done

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        reset_values();
        backup_gate();
        power_gate();
        button_glitch();
        windows_expire();
        home_set();
        reset_again();
        test_done();
    end

    // Whole run needs well under two thousand cycles
    initial
    begin
        #40000;
        num_errors++;
        test_done();
    end
endmodule : tb
